// *** hdl/fwp_pkg.sv ***
package fwp_pkg;

  localparam int UNIT_COUNT   = 286;
  localparam int UNIT_W       = 9;
  localparam int SMALL_COUNT  = 32;
  localparam int PW_W         = 64;

  // byte offsets on the register bus
  localparam logic [7:0] OFS_STATUS  = 8'h00;
  localparam logic [7:0] OFS_WEL     = 8'h04;
  localparam logic [7:0] OFS_OP_ADDR = 8'h08;
  localparam logic [7:0] OFS_OP_CMD  = 8'h0C;
  localparam logic [7:0] OFS_RESULT  = 8'h10;
  localparam logic [7:0] OFS_LOCK    = 8'h14;
  localparam logic [7:0] OFS_PW_LO   = 8'h18;
  localparam logic [7:0] OFS_PW_HI   = 8'h1C;
  localparam logic [7:0] OFS_SPW_LO  = 8'h20;
  localparam logic [7:0] OFS_SPW_HI  = 8'h24;
  localparam logic [7:0] OFS_CONFIG  = 8'h28;

  // status register fields
  localparam int ST_BP_LSB   = 0;
  localparam int ST_BP_W     = 4;
  localparam int ST_SWD_BIT  = 4;
  localparam int ST_QE_BIT   = 5;
  localparam int ST_WP_BIT   = 6;
  localparam logic [5:0] STATUS_RST = 6'h00;

  // protection configuration register fields (one-time programmable)
  localparam int CFG_SSL_BIT  = 0;
  localparam int CFG_PERS_BIT = 1;
  localparam int CFG_PWD_BIT  = 2;
  localparam logic [2:0] CONFIG_RST = 3'h7;

  localparam logic [PW_W-1:0] SPW_RST = 64'hFFFFFFFFFFFFFFFF;
  localparam int RES_PASS_BIT = 0;
  localparam int RES_FAIL_BIT = 1;
  localparam int BLOCK_COUNT  = 256;

  typedef enum logic [3:0] {
    FWP_OP_NONE       = 4'h0,
    FWP_OP_ARRAY_PROG = 4'h1,
    FWP_OP_ARRAY_ERAS = 4'h2,
    FWP_OP_PPB_PROG   = 4'h3,
    FWP_OP_PPB_ERASE  = 4'h4,
    FWP_OP_DYB_CLEAR  = 4'h5,
    FWP_OP_DYB_SET    = 4'h6,
    FWP_OP_LOCK_CLEAR = 4'h7,
    FWP_OP_UNLOCK     = 4'h8
  } fwp_op_e;

endpackage

// *** hdl/fwp_unit_map.sv ***
`timescale 1ns/1ps
// 24-bit byte address to protection unit index
module fwp_unit_map (
  input  wire logic [23:0]               addr,
  input  wire logic                      small_low,
  output logic [fwp_pkg::UNIT_W-1:0]     unit_idx,
  output logic [7:0]                     block_idx
);
  logic [7:0] blk;
  logic [4:0] sec;

  assign blk       = addr[23:16];
  assign sec       = addr[16:12];
  assign block_idx = blk;

  always_comb begin
    if (small_low) begin
      // small sectors in blocks 0..1, blocks 2..255 follow as units 32..285
      if (blk < 8'h02) begin
        unit_idx = {4'h0, sec};
      end else begin
        unit_idx = 9'(blk) + 9'(fwp_pkg::SMALL_COUNT) - 9'h002;
      end
    end else begin
      // mirrored: blocks 0..253 first, small sectors in the top 128K
      if (blk < 8'hFE) begin
        unit_idx = 9'(blk);
      end else begin
        unit_idx = 9'h0FE + {4'h0, sec};
      end
    end
  end
endmodule // fwp_unit_map

// *** hdl/fwp_core.sv ***
`timescale 1ns/1ps
// Contract
// - status protect bits locked only when write-disable is 1 and protect pin low
// - program, erase and status, config or stored-password writes ignored unless write enable latch is set
// - unit protected if block-protect scheme or per-unit scheme protects it
// - one persistent and one dynamic bit per unit; either zero blocks writes
// - 32 small sectors plus 254 blocks form units 0 to 285
// - persistent bits cannot change while the lock reads zero
// - persistent bits start erased so every unit starts unprotected
// - persistent mode sets the lock to one after reset
// - persistent mode: lock-clear forces zero, nothing sets it until reset
// - password mode clears the lock to zero after reset
// - password mode: exact 64-bit match of unlock value sets the lock
// - after lock-clear, unlock is refused until the next reset
// - lock mode chosen by one-time-programmable configuration bits, permanent
// - small-low mapping: units 0-31 sectors, 32-284 blocks 2-254, 285 block 255
// - config bit 2 at zero selects password mode and hides the password
// - persistent-bit command with lock zero fails and alters no persistent bit, but still clears the latch
// - dynamic bits are volatile, individually written, matter when persistent bit is one
module fwp_core #(
  parameter int UNITS = fwp_pkg::UNIT_COUNT
) (
  input  wire logic                ref_clk,
  input  wire logic                nrst,
  input  wire logic [7:0]          avs_address,
  input  wire logic                avs_read,
  input  wire logic                avs_write,
  input  wire logic [31:0]         avs_writedata,
  input  wire logic [3:0]          avs_byteenable,
  output logic [31:0]              avs_readdata,
  output logic                     avs_waitrequest,
  input  wire logic                write_protect_n,
  output logic                     array_op_start,
  output logic                     array_op_erase,
  output logic [23:0]              array_op_addr
);
  logic [1:0]              wp_sync_reg;
  logic                    wp_level;
  logic                    ack_reg;
  logic [31:0]             readdata_reg;
  logic [5:0]              status_reg;
  logic                    wel_reg;
  logic [23:0]             op_addr_reg;
  logic [1:0]              result_reg;
  logic                    lock_reg;
  logic                    init_reg;
  logic                    unlock_dis_reg;
  logic [63:0]             pw_in_reg;
  logic [63:0]             spw_reg    = fwp_pkg::SPW_RST;
  logic [2:0]              config_reg = fwp_pkg::CONFIG_RST;
  logic [UNITS-1:0]        ppb_reg;
  logic [UNITS-1:0]        dyb_reg;
  logic                    start_reg;
  logic                    erase_reg;
  logic [23:0]             start_addr_reg;
  logic [8:0]              unit_idx;
  logic [7:0]              block_idx;
  logic                    do_wr;
  logic                    cmd_wr;
  fwp_pkg::fwp_op_e        cmd;
  logic                    pwd_mode;
  logic                    bp_hit;
  logic                    unit_hit;
  logic                    status_locked;
  logic [31:0]             rd_next;

  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // protect pin is asynchronous to ref_clk
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wp_sync_reg <= 2'h3;
    end else begin
      wp_sync_reg <= {wp_sync_reg[0], write_protect_n};
    end
  end
  assign wp_level = wp_sync_reg[1];

  // one wait cycle per access; effects land on the edge with waitrequest low
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (avs_read | avs_write) & ~ack_reg;
    end
  end
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
  assign do_wr           = avs_write & ack_reg;
  assign cmd_wr          = do_wr & (avs_address == fwp_pkg::OFS_OP_CMD);
  assign cmd             = fwp_pkg::fwp_op_e'(avs_writedata[3:0]);
  assign avs_readdata    = readdata_reg;

  fwp_unit_map i_fwp_unit_map (
    .addr      (op_addr_reg),
    .small_low (config_reg[fwp_pkg::CFG_SSL_BIT]),
    .unit_idx  (unit_idx),
    .block_idx (block_idx)
  );

  assign pwd_mode      = ~config_reg[fwp_pkg::CFG_PWD_BIT];
  assign status_locked = status_reg[fwp_pkg::ST_SWD_BIT] & ~wp_level;
  // block-protect guards the top 2^(n-1) blocks, n = 9 and above guards all
  always_comb begin
    logic [3:0] bp;
    bp = status_reg[fwp_pkg::ST_BP_LSB +: fwp_pkg::ST_BP_W];
    if (bp == 4'h0) begin
      bp_hit = 1'b0;
    end else if (bp >= 4'h9) begin
      bp_hit = 1'b1;
    end else begin
      bp_hit = 9'(block_idx) >= (9'h100 - (9'h001 << (bp - 4'h1)));
    end
  end
  assign unit_hit = ~ppb_reg[unit_idx] | ~dyb_reg[unit_idx];

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      readdata_reg <= 32'h0;
    end else if (avs_read & ~ack_reg) begin
      readdata_reg <= rd_next;
    end
  end

  always_comb begin
    rd_next = 32'h0;
    case (avs_address)
      fwp_pkg::OFS_STATUS:  rd_next = {25'h0, wp_level, status_reg};
      fwp_pkg::OFS_WEL:     rd_next = {31'h0, wel_reg};
      fwp_pkg::OFS_OP_ADDR: rd_next = {8'h0, op_addr_reg};
      fwp_pkg::OFS_RESULT:  rd_next = {30'h0, result_reg};
      fwp_pkg::OFS_LOCK:    rd_next = {31'h0, lock_reg};
      fwp_pkg::OFS_SPW_LO:  rd_next = pwd_mode ? 32'hFFFFFFFF : spw_reg[31:0];
      fwp_pkg::OFS_SPW_HI:  rd_next = pwd_mode ? 32'hFFFFFFFF : spw_reg[63:32];
      fwp_pkg::OFS_CONFIG:  rd_next = {29'h0, config_reg};
      default:              rd_next = 32'h0;
    endcase
  end

  // status bits: write needs the latch and the hardware lock open
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      status_reg <= fwp_pkg::STATUS_RST;
    end else if (do_wr && avs_address == fwp_pkg::OFS_STATUS && wel_reg && !status_locked
                 && avs_byteenable[0]) begin
      status_reg <= avs_writedata[5:0];
    end
  end

  // latch is consumed by every write-class access that it gates
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wel_reg <= 1'b0;
    end else if (do_wr && avs_address == fwp_pkg::OFS_WEL) begin
      wel_reg <= avs_writedata[0];
    end else if (do_wr && (avs_address == fwp_pkg::OFS_STATUS ||
                           avs_address == fwp_pkg::OFS_CONFIG ||
                           avs_address == fwp_pkg::OFS_SPW_LO ||
                           avs_address == fwp_pkg::OFS_SPW_HI)) begin
      wel_reg <= 1'b0;
    end else if (cmd_wr && cmd != fwp_pkg::FWP_OP_UNLOCK) begin
      wel_reg <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      op_addr_reg <= 24'h0;
      pw_in_reg   <= 64'h0;
    end else if (do_wr) begin
      if (avs_address == fwp_pkg::OFS_OP_ADDR) begin
        op_addr_reg <= 24'(be_merge({8'h0, op_addr_reg}, avs_writedata, avs_byteenable));
      end
      if (avs_address == fwp_pkg::OFS_PW_LO) begin
        pw_in_reg[31:0] <= be_merge(pw_in_reg[31:0], avs_writedata, avs_byteenable);
      end
      if (avs_address == fwp_pkg::OFS_PW_HI) begin
        pw_in_reg[63:32] <= be_merge(pw_in_reg[63:32], avs_writedata, avs_byteenable);
      end
    end
  end

  // one-time-programmable: bits only go from 1 to 0, mode bits freeze once either is 0
  // no nrst here: a chosen lock mode must survive hardware reset, so these start erased only
  always_ff @(posedge ref_clk) begin
    if (do_wr && wel_reg) begin
      if (avs_address == fwp_pkg::OFS_CONFIG &&
          config_reg[fwp_pkg::CFG_PWD_BIT] && config_reg[fwp_pkg::CFG_PERS_BIT]) begin
        config_reg <= config_reg & avs_writedata[2:0];
      end
      if (avs_address == fwp_pkg::OFS_SPW_LO && !pwd_mode) begin
        spw_reg[31:0] <= spw_reg[31:0] & avs_writedata;
      end
      if (avs_address == fwp_pkg::OFS_SPW_HI && !pwd_mode) begin
        spw_reg[63:32] <= spw_reg[63:32] & avs_writedata;
      end
    end
  end

  // lock is caught from the mode one edge after reset release, not in the reset branch
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      init_reg <= 1'b1;
    end else begin
      init_reg <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      lock_reg <= 1'b0;
    end else if (init_reg) begin
      lock_reg <= ~pwd_mode;
    end else if (cmd_wr && cmd == fwp_pkg::FWP_OP_LOCK_CLEAR && wel_reg) begin
      lock_reg <= 1'b0;
    end else if (cmd_wr && cmd == fwp_pkg::FWP_OP_UNLOCK && pwd_mode && !unlock_dis_reg
                 && pw_in_reg == spw_reg) begin
      lock_reg <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      unlock_dis_reg <= 1'b0;
    end else if (cmd_wr && cmd == fwp_pkg::FWP_OP_LOCK_CLEAR && wel_reg) begin
      unlock_dis_reg <= 1'b1;
    end
  end

  // persistent bits are modelled as restored to erased on every nrst reset
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ppb_reg <= '1;
    end else if (cmd_wr && wel_reg && lock_reg) begin
      if (cmd == fwp_pkg::FWP_OP_PPB_PROG) begin
        ppb_reg[unit_idx] <= 1'b0;
      end else if (cmd == fwp_pkg::FWP_OP_PPB_ERASE) begin
        ppb_reg <= '1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      dyb_reg <= '1;
    end else if (cmd_wr && wel_reg) begin
      if (cmd == fwp_pkg::FWP_OP_DYB_CLEAR) begin
        dyb_reg[unit_idx] <= 1'b0;
      end else if (cmd == fwp_pkg::FWP_OP_DYB_SET) begin
        dyb_reg[unit_idx] <= 1'b1;
      end
    end
  end

  // result and array start are decided on the command write
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      result_reg     <= 2'h0;
      start_reg      <= 1'b0;
      erase_reg      <= 1'b0;
      start_addr_reg <= 24'h0;
    end else begin
      start_reg <= 1'b0;
      if (cmd_wr) begin
        result_reg <= 2'h2;
        case (cmd)
          fwp_pkg::FWP_OP_ARRAY_PROG, fwp_pkg::FWP_OP_ARRAY_ERAS: begin
            if (wel_reg && !bp_hit && !unit_hit) begin
              result_reg     <= 2'h1;
              start_reg      <= 1'b1;
              erase_reg      <= (cmd == fwp_pkg::FWP_OP_ARRAY_ERAS);
              start_addr_reg <= op_addr_reg;
            end
          end
          fwp_pkg::FWP_OP_PPB_PROG, fwp_pkg::FWP_OP_PPB_ERASE: begin
            if (wel_reg && lock_reg) begin
              result_reg <= 2'h1;
            end
          end
          fwp_pkg::FWP_OP_DYB_CLEAR, fwp_pkg::FWP_OP_DYB_SET,
          fwp_pkg::FWP_OP_LOCK_CLEAR: begin
            if (wel_reg) begin
              result_reg <= 2'h1;
            end
          end
          fwp_pkg::FWP_OP_UNLOCK: begin
            if (pwd_mode && !unlock_dis_reg && pw_in_reg == spw_reg) begin
              result_reg <= 2'h1;
            end
          end
          default: result_reg <= 2'h2;
        endcase
      end
    end
  end

  assign array_op_start = start_reg;
  assign array_op_erase = erase_reg;
  assign array_op_addr  = start_addr_reg;

  sequence array_cmd_s;
    cmd_wr && (cmd == fwp_pkg::FWP_OP_ARRAY_PROG || cmd == fwp_pkg::FWP_OP_ARRAY_ERAS);
  endsequence
  sequence ppb_cmd_s;
    cmd_wr && (cmd == fwp_pkg::FWP_OP_PPB_PROG || cmd == fwp_pkg::FWP_OP_PPB_ERASE);
  endsequence

  sr_hw_lock_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    do_wr && avs_address == fwp_pkg::OFS_STATUS && status_locked |=> $stable(status_reg))
    else $error("status bits changed while hardware locked");
  wel_gate_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    array_cmd_s and !wel_reg |=> result_reg == 2'h2 && !array_op_start)
    else $error("array op ran without write enable latch");
  bp_or_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    array_cmd_s and bp_hit |=> !array_op_start ##1 !array_op_start)
    else $error("array op ran in block-protected area");
  unit_bits_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    array_cmd_s and unit_hit |=> result_reg[fwp_pkg::RES_FAIL_BIT])
    else $error("array op passed on protected unit");
  persistent_bit_lock_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    ppb_cmd_s and !lock_reg |=> $stable(ppb_reg) && result_reg == 2'h2)
    else $error("persistent bits changed while locked");
  lock_init_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    $fell(init_reg) |-> lock_reg == ~pwd_mode)
    else $error("lock not set from mode after reset");
  lock_stays_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    !init_reg && !pwd_mode && !lock_reg |=> !lock_reg)
    else $error("persistent-mode lock rose without reset");
  unlock_dis_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    unlock_dis_reg && !lock_reg && !init_reg |=> !lock_reg [*2])
    else $error("unlock accepted after lock-clear");
  otp_bits_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    ##1 (config_reg & ~$past(config_reg)) == 3'h0)
    else $error("one-time bit returned to one");
  bus_answer_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (avs_read || avs_write) && !ack_reg |=> !avs_waitrequest)
    else $error("waitrequest held longer than one cycle");
endmodule // fwp_core

// *** tb/fwp_host_model.sv ***
`timescale 1ns/1ps
// register-bus master standing in for the serial host; one request at a time
module fwp_host_model (
  input  wire logic        ref_clk,
  output logic [7:0]       avs_address,
  output logic             avs_read,
  output logic             avs_write,
  output logic [31:0]      avs_writedata,
  output logic [3:0]       avs_byteenable,
  input  wire logic [31:0] avs_readdata,
  input  wire logic        avs_waitrequest
);
  initial begin
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
  end

  // request held until the edge that samples waitrequest low; no fixed latency assumed
  task automatic xfer(input logic wr_en, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr_en;
    avs_read <= ~wr_en;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  // latch set before each command or status, config or stored-password write, except in the no-latch checks
  task automatic write_enable_latch();
    logic [31:0] q;
    xfer(1'b1, fwp_pkg::OFS_WEL, 32'h1, q);
  endtask
endmodule // fwp_host_model

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  logic        ref_clk;
  logic        nrst;
  logic        write_protect_n;
  logic [7:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        array_op_start;
  logic        array_op_erase;
  logic [23:0] array_op_addr;
  logic [23:0] start_addr;
  logic        start_erase;
  int          n_errors;
  int          cmp_count;
  int          n_start;
  int          cycles;

  fwp_core i_fwp_core (.ref_clk(ref_clk), .nrst(nrst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .write_protect_n(write_protect_n),
    .array_op_start(array_op_start), .array_op_erase(array_op_erase),
    .array_op_addr(array_op_addr));

  fwp_host_model i_fwp_host_model (.ref_clk(ref_clk), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    if (array_op_start === 1'b1) begin
      n_start++;
      start_addr = array_op_addr;
      start_erase = array_op_erase;
    end
  end

  // generous ceiling: the whole sequence needs well under 3000 cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    i_fwp_host_model.xfer(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    i_fwp_host_model.xfer(1'b0, a, 32'h0, q);
    chk(what, q, exp);
  endtask

  task automatic wel_wr(input logic [7:0] a, input logic [31:0] d);
    i_fwp_host_model.write_enable_latch();
    wr(a, d);
  endtask

  // one command with latch set; array ops also judged by the start pulse count
  task automatic op(input fwp_pkg::fwp_op_e c, input logic [23:0] a, input logic ok);
    int s;
    logic arr;
    s = n_start;
    arr = (c == fwp_pkg::FWP_OP_ARRAY_PROG) || (c == fwp_pkg::FWP_OP_ARRAY_ERAS);
    wel_wr(fwp_pkg::OFS_OP_ADDR, {8'h00, a});
    wr(fwp_pkg::OFS_OP_CMD, {28'h0, c});
    rd_chk("result", fwp_pkg::OFS_RESULT, ok ? 32'h1 : 32'h2);
    if (arr)
      chk("start count", 32'(n_start - s), {31'h0, ok});
    if (arr && ok)
      chk("op addr", {7'h00, start_erase, start_addr},
          {7'h00, c == fwp_pkg::FWP_OP_ARRAY_ERAS, a});
  endtask

  task automatic hw_reset();
    @(posedge ref_clk);
    nrst <= 1'b0;
    repeat (16) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge ref_clk);
  endtask

  task automatic t_reset_vals();
    rd_chk("lock", fwp_pkg::OFS_LOCK, 32'h1);
    rd_chk("config", fwp_pkg::OFS_CONFIG, 32'h7);
    rd_chk("status", fwp_pkg::OFS_STATUS, 32'h40);
    rd_chk("stored pw", fwp_pkg::OFS_SPW_LO, 32'hFFFFFFFF);
    op(fwp_pkg::FWP_OP_ARRAY_PROG, 24'h000000, 1'b1);
    $display("test reset values done");
  endtask

  task automatic t_status();
    wr(fwp_pkg::OFS_STATUS, 32'h01);
    rd_chk("status no latch", fwp_pkg::OFS_STATUS, 32'h40);
    wr(fwp_pkg::OFS_OP_CMD, 32'h1);
    rd_chk("result no latch", fwp_pkg::OFS_RESULT, 32'h2);
    wel_wr(fwp_pkg::OFS_STATUS, 32'h01);
    rd_chk("status bp", fwp_pkg::OFS_STATUS, 32'h41);
    op(fwp_pkg::FWP_OP_ARRAY_PROG, 24'hFF0000, 1'b0);
    op(fwp_pkg::FWP_OP_ARRAY_ERAS, 24'hFE0000, 1'b1);
    wel_wr(fwp_pkg::OFS_STATUS, 32'h31);
    write_protect_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    wel_wr(fwp_pkg::OFS_STATUS, 32'h00);
    rd_chk("status pin low", fwp_pkg::OFS_STATUS, 32'h31);
    write_protect_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    wel_wr(fwp_pkg::OFS_STATUS, 32'h00);
    rd_chk("status pin high", fwp_pkg::OFS_STATUS, 32'h40);
    $display("test status protection done");
  endtask

  task automatic t_units();
    op(fwp_pkg::FWP_OP_DYB_CLEAR, 24'h020000, 1'b1);
    op(fwp_pkg::FWP_OP_ARRAY_PROG, 24'h02F000, 1'b0);
    op(fwp_pkg::FWP_OP_ARRAY_PROG, 24'h030000, 1'b1);
    op(fwp_pkg::FWP_OP_DYB_SET, 24'h020000, 1'b1);
    op(fwp_pkg::FWP_OP_ARRAY_ERAS, 24'h020000, 1'b1);
    op(fwp_pkg::FWP_OP_PPB_PROG, 24'h001000, 1'b1);
    op(fwp_pkg::FWP_OP_ARRAY_PROG, 24'h001FFF, 1'b0);
    op(fwp_pkg::FWP_OP_ARRAY_PROG, 24'h000000, 1'b1);
    op(fwp_pkg::FWP_OP_PPB_PROG, 24'hFF8000, 1'b1);
    op(fwp_pkg::FWP_OP_ARRAY_ERAS, 24'hFF0000, 1'b0);
    op(fwp_pkg::FWP_OP_ARRAY_ERAS, 24'hFE0000, 1'b1);
    op(fwp_pkg::FWP_OP_PPB_ERASE, 24'h000000, 1'b1);
    op(fwp_pkg::FWP_OP_ARRAY_PROG, 24'h001000, 1'b1);
    wel_wr(fwp_pkg::OFS_CONFIG, 32'h6);
    rd_chk("config small high", fwp_pkg::OFS_CONFIG, 32'h6);
    op(fwp_pkg::FWP_OP_PPB_PROG, 24'hFE1000, 1'b1);
    op(fwp_pkg::FWP_OP_ARRAY_PROG, 24'hFE1800, 1'b0);
    op(fwp_pkg::FWP_OP_ARRAY_PROG, 24'hFE2000, 1'b1);
    op(fwp_pkg::FWP_OP_PPB_PROG, 24'h0A0000, 1'b1);
    op(fwp_pkg::FWP_OP_ARRAY_ERAS, 24'h0AFFFF, 1'b0);
    op(fwp_pkg::FWP_OP_PPB_ERASE, 24'h000000, 1'b1);
    $display("test protection units done");
  endtask

  task automatic t_pers_lock();
    op(fwp_pkg::FWP_OP_LOCK_CLEAR, 24'h000000, 1'b1);
    rd_chk("lock cleared", fwp_pkg::OFS_LOCK, 32'h0);
    op(fwp_pkg::FWP_OP_UNLOCK, 24'h000000, 1'b0);
    rd_chk("lock stays", fwp_pkg::OFS_LOCK, 32'h0);
    op(fwp_pkg::FWP_OP_PPB_PROG, 24'h001000, 1'b0);
    op(fwp_pkg::FWP_OP_ARRAY_PROG, 24'h001000, 1'b1);
    hw_reset();
    rd_chk("lock after reset", fwp_pkg::OFS_LOCK, 32'h1);
    $display("test persistent lock done");
  endtask

  task automatic t_password();
    wel_wr(fwp_pkg::OFS_SPW_LO, 32'h12345678);
    wel_wr(fwp_pkg::OFS_SPW_HI, 32'h9ABCDEF0);
    rd_chk("stored pw open", fwp_pkg::OFS_SPW_LO, 32'h12345678);
    wel_wr(fwp_pkg::OFS_CONFIG, 32'h3);
    rd_chk("stored pw hidden", fwp_pkg::OFS_SPW_LO, 32'hFFFFFFFF);
    wel_wr(fwp_pkg::OFS_CONFIG, 32'h7);
    rd_chk("config frozen", fwp_pkg::OFS_CONFIG, 32'h2);
    hw_reset();
    rd_chk("config kept", fwp_pkg::OFS_CONFIG, 32'h2);
    rd_chk("lock pw reset", fwp_pkg::OFS_LOCK, 32'h0);
    wr(fwp_pkg::OFS_PW_HI, 32'h9ABCDEF0);
    wr(fwp_pkg::OFS_PW_LO, 32'h12345679);
    op(fwp_pkg::FWP_OP_UNLOCK, 24'h000000, 1'b0);
    wr(fwp_pkg::OFS_PW_LO, 32'h12345678);
    op(fwp_pkg::FWP_OP_UNLOCK, 24'h000000, 1'b1);
    rd_chk("lock unlocked", fwp_pkg::OFS_LOCK, 32'h1);
    op(fwp_pkg::FWP_OP_LOCK_CLEAR, 24'h000000, 1'b1);
    op(fwp_pkg::FWP_OP_UNLOCK, 24'h000000, 1'b0);
    rd_chk("lock relocked", fwp_pkg::OFS_LOCK, 32'h0);
    op(fwp_pkg::FWP_OP_PPB_ERASE, 24'h000000, 1'b0);
    $display("test password mode done");
  endtask

  initial begin
    nrst = 1'b0;
    write_protect_n = 1'b1;
    n_errors = 0;
    cmp_count = 0;
    n_start = 0;
    cycles = 0;
    hw_reset();
    t_reset_vals();
    t_status();
    t_units();
    t_pers_lock();
    t_password();
    end_of_test();
  end
endmodule // tb_top
